/* File: logic/uaf_pkg.sv */
// Purpose: Shared constants for the serial receiver address filter
// Assumes: APB byte addresses are four times the printed register index
// Notes: Offsets, fields, timing counts and the address, mask and control resets live here
// Function
// - Stop check only in async modes, when enabled
// - Invalid stop bit sets framing error flag
// - Framing error sticky until software or reset
// - With check enabled, receive flag at stop
// - Address filter active when multiproc set, async modes only
// - Filtered address frame flags only on match
// - 8-bit mode: stop is ninth bit, valid
// - Shift-register mode ignores multiproc enable
// - Accept given or broadcast address match
// - Mask zero bits are don't-care for given
// - All-ones mask gives exact unique address
// - Broadcast is address OR mask, zeros ignored
// - Reset clears address and mask to zero
// - Async modes full duplex, independent baud
// - Control bit 7 is error or mode bit
// - 8-bit mode, no multiproc: store stop bit
package uaf_pkg;
  // Register indices as printed; byte address is four times these
  localparam logic [7:0] IDX_SLAVE_ADDRESS = 8'ha9;
  localparam logic [7:0] IDX_SLAVE_ADDRESS_MASK = 8'hb9;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hc0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hc1;
  // Serial control fields
  localparam int SC_BIT7 = 7;
  localparam int SC_MODE1 = 6;
  localparam int SC_MULTIPROC = 5;
  localparam int SC_RX_ENABLE = 4;
  localparam int SC_TX_NINTH = 3;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_DONE = 0;
  // Power control field
  localparam int PC_FRAMING_CHECK = 6;
  // Interrupt status fields
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_FRAMING = 1;
  localparam int IRQ_TX_DONE = 2;
  // Reset values
  localparam logic [7:0] RST_ADDRESS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  // Timing: default bit time and derived cycle count
  localparam int CLK_PERIOD_NS = 4;
  localparam int BIT_TIME_NS = 8680;
  localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
  // Serial modes
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_ASYNC8 = 2'h1,
    MODE_ASYNC9F = 2'h2,
    MODE_ASYNC9 = 2'h3
  } uaf_mode_type;
  // Receiver states, Gray along start, data, ninth, stop
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_NINTH = 3'h2,
    RX_STOP = 3'h6
  } uaf_rx_state_type;
  // Address match against given and broadcast addresses
  function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] adr,
                                      input logic [7:0] msk);
    logic given;
    logic bcast;
    given = (((rx ^ adr) & msk) == 8'h00);
    bcast = (((rx ^ (adr | msk)) & (adr | msk)) == 8'h00);
    addr_match = given | bcast;
  endfunction
endpackage

/* File: logic/uaf_baud_tick.sv */
// Purpose: Divider producing one-cycle bit and half-bit enables
// Assumes: Restart realigns phase to a frame start edge
// Notes: Count width follows the divide parameter
`timescale 1ns/1ns
module uaf_baud_tick #(
  parameter int DIVIDE = uaf_pkg::BIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic restart,
  output logic halfTick,
  output logic bitTick
);
  import uaf_pkg::*;
  localparam int CW = $clog2(DIVIDE + 1);
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);
  localparam logic [CW-1:0] HALF = CW'(DIVIDE / 2);
  logic [CW-1:0] count_ff; // Cycle counter within a bit
  // Count and wrap, realign on restart
  always_ff @(posedge clk_sys) begin
    if (rst || restart || count_ff == LAST) begin
      count_ff <= '0;
    end else begin
      count_ff <= count_ff + CW'(1);
    end
  end
  assign halfTick = (count_ff == HALF) && !restart;
  assign bitTick = (count_ff == LAST) && !restart;
endmodule

/* File: logic/uaf_apb_regs.sv */
// Purpose: APB slave holding address, mask, irq mask registers
// Assumes: Zero wait states; unmapped reads return zero with pslverr
// Notes: Control and status registers live in the top
`timescale 1ns/1ns
module uaf_apb_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0] extRdata,
  input wire logic extHit,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wrStrobe,
  output logic [7:0] slaveAddress,
  output logic [7:0] slaveAddressMask,
  output logic [2:0] irqMask
);
  import uaf_pkg::*;
  logic [7:0] idx; // Register index from byte address
  logic hit; // Local or external register selected
  logic access; // Access phase
  assign idx = paddr[9:2];
  assign access = psel && penable;
  assign wrStrobe = access && pwrite;
  assign pready = 1'b1;
  assign hit = extHit || idx == IDX_SLAVE_ADDRESS || idx == IDX_SLAVE_ADDRESS_MASK
               || idx == IDX_IRQ_MASK;
  assign pslverr = access && !hit;
  // Writable filter and mask registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      slaveAddress <= RST_ADDRESS;
      slaveAddressMask <= RST_MASK;
      irqMask <= 3'h0;
    end else if (wrStrobe) begin
      if (idx == IDX_SLAVE_ADDRESS) slaveAddress <= pwdata[7:0];
      if (idx == IDX_SLAVE_ADDRESS_MASK) slaveAddressMask <= pwdata[7:0];
      if (idx == IDX_IRQ_MASK) irqMask <= pwdata[2:0];
    end
  end
  // Read mux, combinational during access phase
  always_comb begin
    prdata = 32'h0;
    if (idx == IDX_SLAVE_ADDRESS) prdata = {24'h0, slaveAddress};
    else if (idx == IDX_SLAVE_ADDRESS_MASK) prdata = {24'h0, slaveAddressMask};
    else if (idx == IDX_IRQ_MASK) prdata = {29'h0, irqMask};
    else if (extHit) prdata = {24'h0, extRdata};
  end
endmodule

/* File: logic/uaf_receiver.sv */
// Purpose: Serial receiver with framing check and address filtering
// Assumes: Line input is synchronous to clk_sys; baud fixed by parameter
// Notes: Transmit path only reflects its flags; mode 0 receive not modelled
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
module uaf_receiver #(
  parameter int BIT_DIVIDE = uaf_pkg::BIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxLine,
  input wire logic txDoneEvent,
  output logic [7:0] rxData,
  output logic irq
);
  import uaf_pkg::*;

  // Register file outputs and bus decode
  logic wrStrobe; // APB write in access phase
  logic [7:0] slaveAddress; // Address register
  logic [7:0] slaveAddressMask; // Mask register
  logic [2:0] irqMask; // Interrupt mask
  logic [7:0] extRdata; // Read data of top registers
  logic extHit; // Top register selected
  logic [7:0] idx; // Register index

  // Control, power and interrupt state
  logic [7:0] serialControl_ff; // Bits other than bit 7
  logic modeBit0_ff; // Mode select bit zero
  logic framingErrorFlag_ff; // Sticky framing error
  logic [7:0] powerControl_ff; // Power control register
  logic [2:0] irqStatus_ff; // Sticky interrupt causes
  logic framingCheckEnable; // Framing check enable

  // Receiver sequencing and datapath
  uaf_mode_type mode; // Current serial mode
  uaf_rx_state_type state_ff; // Receiver state
  uaf_rx_state_type nxt_state;
  logic [3:0] bitCount_ff; // Data bits received
  logic [7:0] shift_ff; // Data shift register
  logic ninth_ff; // Ninth bit sampled
  logic restart; // Realign divider
  logic halfTick; // Mid-bit sample enable

  // Frame level events and decisions
  logic frameDone; // Stop bit sampled
  logic stopValid; // Stop bit high
  logic filterOn; // Address filter active
  logic ninthBit; // Effective ninth bit
  logic accept; // Frame raises receive flag
  logic errSet; // Framing error event
  logic rxDoneSet; // Receive complete event
  logic lineFall; // Start edge detect
  logic linePrev_ff; // Previous line level
  logic ctrlWrite; // Write to serial control
  logic statWrite; // Write to irq status

  // Bus slave with filter address, mask and irq mask
  uaf_apb_regs u_regs (
    .clk_sys(clk_sys),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .extRdata(extRdata),
    .extHit(extHit),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wrStrobe(wrStrobe),
    .slaveAddress(slaveAddress),
    .slaveAddressMask(slaveAddressMask),
    .irqMask(irqMask)
  );

  // Mid-bit enables; the end-of-bit pulse is not needed here
  uaf_baud_tick #(.DIVIDE(BIT_DIVIDE)) u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(restart),
    .halfTick(halfTick),
    .bitTick()
  );

  // Decode of registers held here
  assign idx = paddr[9:2];
  assign extHit = idx == IDX_SERIAL_CONTROL || idx == IDX_POWER_CONTROL
                  || idx == IDX_IRQ_STATUS;
  assign ctrlWrite = wrStrobe && idx == IDX_SERIAL_CONTROL;
  assign statWrite = wrStrobe && idx == IDX_IRQ_STATUS;
  assign framingCheckEnable = powerControl_ff[PC_FRAMING_CHECK];
  assign mode = uaf_mode_type'({modeBit0_ff, serialControl_ff[SC_MODE1]});

  // Read mux for control, power and status
  // Bit 7 shows the error flag or the mode bit, by check enable
  always_comb begin
    extRdata = 8'h00;
    if (idx == IDX_SERIAL_CONTROL) begin
      extRdata = serialControl_ff;
      extRdata[SC_BIT7] = framingCheckEnable ? framingErrorFlag_ff : modeBit0_ff;
    end else if (idx == IDX_POWER_CONTROL) begin
      extRdata = powerControl_ff;
    end else if (idx == IDX_IRQ_STATUS) begin
      extRdata = {5'h0, irqStatus_ff};
    end
  end

  // Filter only in async modes with multiproc set
  // Shift-register mode forces the filter off whatever multiproc says
  assign filterOn = serialControl_ff[SC_MULTIPROC] && mode != MODE_SHIFT;
  // Async 8-bit mode uses the stop bit as ninth bit
  // A bad stop in 8-bit mode therefore also fails the address test
  assign ninthBit = (mode == MODE_ASYNC8) ? rxLine : ninth_ff;
  assign stopValid = rxLine;
  assign frameDone = state_ff == RX_STOP && halfTick;
  // Frame acceptance under filtering
  // Unfiltered frames are always taken; the address test uses the byte
  always_comb begin
    accept = 1'b1;
    if (filterOn) begin
      accept = ninthBit && addr_match(shift_ff, slaveAddress, slaveAddressMask);
      if (mode == MODE_ASYNC8) accept = accept && stopValid;
    end
  end
  // Events: check enabled in async modes only
  // Error and acceptance are independent; a rejected frame can still err
  assign errSet = frameDone && !stopValid && framingCheckEnable && mode != MODE_SHIFT;
  assign rxDoneSet = frameDone && accept && !serialControl_ff[SC_RX_DONE];
  assign lineFall = linePrev_ff && !rxLine;
  assign restart = state_ff == RX_IDLE && lineFall;

  // Receiver sequencing; async modes only, concurrent with transmit
  // A start bit that is high again at mid-bit is a glitch: back to idle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RX_IDLE: begin
        if (lineFall && serialControl_ff[SC_RX_ENABLE] && mode != MODE_SHIFT) begin
          nxt_state = RX_START;
        end
      end
      // Confirm the start bit at its middle
      RX_START: begin
        if (halfTick) nxt_state = rxLine ? RX_IDLE : RX_DATA;
      end
      // Eight data samples, one per bit
      RX_DATA: begin
        if (halfTick && bitCount_ff == 4'h7) begin
          nxt_state = (mode == MODE_ASYNC8) ? RX_STOP : RX_NINTH;
        end
      end
      // Ninth bit only in the 9-bit modes
      RX_NINTH: begin
        if (halfTick) nxt_state = RX_STOP;
      end
      // Stop sample ends the frame
      RX_STOP: begin
        if (halfTick) nxt_state = RX_IDLE;
      end
      default: nxt_state = RX_IDLE;
    endcase
  end

  // State and line history
  // Line history resets to the idle level so reset makes no false start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= RX_IDLE;
      linePrev_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      linePrev_ff <= rxLine;
    end
  end

  // Data capture, LSB first
  // The ninth bit keeps its old value in 8-bit mode, where it is unused
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bitCount_ff <= 4'h0;
      shift_ff <= 8'h00;
      ninth_ff <= 1'b0;
    end else if (state_ff == RX_START) begin
      bitCount_ff <= 4'h0;
    end else if (state_ff == RX_DATA && halfTick) begin
      shift_ff <= {rxLine, shift_ff[7:1]};
      bitCount_ff <= bitCount_ff + 4'h1;
    end else if (state_ff == RX_NINTH && halfTick) begin
      ninth_ff <= rxLine;
    end
  end

  // Received data buffer loads on accepted frame
  // A frame dropped while the flag is up leaves the old byte in place
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxData <= 8'h00;
    end else if (rxDoneSet) begin
      rxData <= shift_ff;
    end
  end

  // Serial control: software writes, hardware sets flags
  // The flag set is written last so it wins over a clearing write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      serialControl_ff <= RST_CONTROL;
      modeBit0_ff <= 1'b0;
    end else begin
      if (ctrlWrite) begin
        serialControl_ff <= {1'b0, pwdata[6:0]};
        if (!framingCheckEnable) modeBit0_ff <= pwdata[SC_BIT7];
      end
      if (rxDoneSet) begin
        serialControl_ff[SC_RX_DONE] <= 1'b1;
        if (mode == MODE_ASYNC8) begin
          if (!serialControl_ff[SC_MULTIPROC]) begin
            serialControl_ff[SC_RX_NINTH] <= rxLine;
          end
        end else begin
          serialControl_ff[SC_RX_NINTH] <= ninth_ff;
        end
      end
      if (txDoneEvent) serialControl_ff[SC_TX_DONE] <= 1'b1;
    end
  end

  // Sticky framing error, only software write or reset clears
  // Set wins over a clearing write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      framingErrorFlag_ff <= 1'b0;
    end else if (errSet) begin
      framingErrorFlag_ff <= 1'b1;
    end else if (ctrlWrite && framingCheckEnable) begin
      framingErrorFlag_ff <= pwdata[SC_BIT7];
    end
  end

  // Power control register
  // Only the framing check enable bit is used by this block
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      powerControl_ff <= 8'h00;
    end else if (wrStrobe && idx == IDX_POWER_CONTROL) begin
      powerControl_ff <= pwdata[7:0];
    end
  end

  // Interrupt status, write one to clear, set wins
  // A cleared cause drops the level output on the next cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqStatus_ff <= 3'h0;
    end else begin
      irqStatus_ff <= (irqStatus_ff & ~(statWrite ? pwdata[2:0] : 3'h0))
                      | {txDoneEvent, errSet, rxDoneSet};
    end
  end
  assign irq = |(irqStatus_ff & irqMask);

  // Error flag never drops without a write or reset
  chk_error_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(framingErrorFlag_ff) |-> $past(ctrlWrite)) else $error("framing flag lost");
  chk_error_set: assert property (@(posedge clk_sys) disable iff (rst)
    errSet |=> framingErrorFlag_ff) else $error("framing error not set");
  chk_no_check_off: assert property (@(posedge clk_sys) disable iff (rst)
    !framingCheckEnable |-> !errSet) else $error("check while disabled");
  chk_rx_at_stop: assert property (@(posedge clk_sys) disable iff (rst)
    rxDoneSet |-> state_ff == RX_STOP) else $error("receive flag off stop");
  chk_filter_miss: assert property (@(posedge clk_sys) disable iff (rst)
    (frameDone && filterOn && !addr_match(shift_ff, slaveAddress, slaveAddressMask))
    |=> !$rose(serialControl_ff[SC_RX_DONE])) else $error("unmatched address flagged");
  chk_data_frame: assert property (@(posedge clk_sys) disable iff (rst)
    (frameDone && filterOn && mode != MODE_ASYNC8 && !ninth_ff) |-> !rxDoneSet)
    else $error("data frame flagged");
  chk_mode8_stop: assert property (@(posedge clk_sys) disable iff (rst)
    (frameDone && filterOn && mode == MODE_ASYNC8 && !rxLine) |-> !rxDoneSet)
    else $error("bad stop accepted");
  chk_shift_nofilter: assert property (@(posedge clk_sys) disable iff (rst)
    mode == MODE_SHIFT |-> !filterOn) else $error("filter in shift mode");
  chk_bit7_view: assert property (@(posedge clk_sys) disable iff (rst)
    (psel && idx == IDX_SERIAL_CONTROL && framingCheckEnable)
    |-> prdata[SC_BIT7] == framingErrorFlag_ff) else $error("bit 7 view wrong");
  chk_reset_addr: assert property (@(posedge clk_sys)
    rst |=> slaveAddress == RST_ADDRESS && slaveAddressMask == RST_MASK)
    else $error("address reset wrong");
  chk_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(irqStatus_ff[IRQ_RX_DONE]) && irqMask[IRQ_RX_DONE] |-> irq)
    else $error("irq not raised");

  // Receive flag and buffer follow accepted frames only
  chk_flag_on_accept: assert property (@(posedge clk_sys) disable iff (rst)
    rxDoneSet |=> serialControl_ff[SC_RX_DONE]) else $error("receive flag not set");
  chk_data_loaded: assert property (@(posedge clk_sys) disable iff (rst)
    rxDoneSet |=> rxData == $past(shift_ff)) else $error("receive data not loaded");
  chk_filter_off: assert property (@(posedge clk_sys) disable iff (rst)
    (frameDone && !filterOn && !serialControl_ff[SC_RX_DONE]) |-> rxDoneSet)
    else $error("unfiltered frame dropped");
  chk_stop_stored: assert property (@(posedge clk_sys) disable iff (rst)
    (rxDoneSet && mode == MODE_ASYNC8 && !serialControl_ff[SC_MULTIPROC])
    |=> serialControl_ff[SC_RX_NINTH] == $past(rxLine)) else $error("stop bit not stored");

  // Address recognition against the register contents
  chk_broadcast_hit: assert property (@(posedge clk_sys) disable iff (rst)
    (frameDone && filterOn && ninthBit && stopValid && !serialControl_ff[SC_RX_DONE]
    && shift_ff == (slaveAddress | slaveAddressMask)) |-> rxDoneSet)
    else $error("broadcast address missed");
  chk_given_hit: assert property (@(posedge clk_sys) disable iff (rst)
    (frameDone && filterOn && ninthBit && stopValid && !serialControl_ff[SC_RX_DONE]
    && ((shift_ff & slaveAddressMask) == (slaveAddress & slaveAddressMask))) |-> rxDoneSet)
    else $error("given address missed");
  chk_exact_only: assert property (@(posedge clk_sys) disable iff (rst)
    (frameDone && filterOn && slaveAddressMask == 8'hff && shift_ff != slaveAddress
    && shift_ff != 8'hff) |-> !rxDoneSet) else $error("inexact address taken");

  // Framing flag, control view and mode limits
  chk_error_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (framingErrorFlag_ff && !ctrlWrite) |=> framingErrorFlag_ff)
    else $error("framing flag dropped");
  chk_error_async: assert property (@(posedge clk_sys) disable iff (rst)
    errSet |-> frameDone && mode != MODE_SHIFT) else $error("framing check outside frame");
  chk_status_err: assert property (@(posedge clk_sys) disable iff (rst)
    errSet |=> irqStatus_ff[IRQ_FRAMING]) else $error("framing cause not set");
  chk_mode_view: assert property (@(posedge clk_sys) disable iff (rst)
    (psel && idx == IDX_SERIAL_CONTROL && !framingCheckEnable)
    |-> prdata[SC_BIT7] == modeBit0_ff) else $error("bit 7 mode view wrong");
  chk_shift_no_rx: assert property (@(posedge clk_sys) disable iff (rst)
    (mode == MODE_SHIFT && state_ff == RX_IDLE) |=> state_ff == RX_IDLE)
    else $error("receive started in shift mode");
  chk_tx_flag: assert property (@(posedge clk_sys) disable iff (rst)
    txDoneEvent |=> serialControl_ff[SC_TX_DONE]) else $error("transmit flag not set");
  chk_irq_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    irqStatus_ff == 3'h0 |-> !irq) else $error("irq without cause");
endmodule

/* File: sim/uaf_serial_node.sv */
// Purpose: Remote serial node driving frames onto the receive line
// Assumes: One bit lasts BIT clocks; the line idles high
// Notes: Ninth bit is optional; the stop level is chosen per frame
`timescale 1ns/1ns
module uaf_serial_node #(
  parameter int BIT = 16
) (
  input wire logic clk_sys,
  output logic rxLine
);
  // Line idles high between frames
  initial rxLine = 1'b1;
  // Hold one level for a whole bit time
  task automatic put(input logic v);
    rxLine <= v;
    repeat (BIT) @(posedge clk_sys);
  endtask
  // Start, eight data bits LSB first, optional ninth, stop
  task automatic send(input logic [7:0] d, input logic nine, input logic b9, input logic stp);
    @(posedge clk_sys);
    put(1'b0);
    for (int i = 0; i < 8; i++) put(d[i]);
    if (nine) put(b9);
    put(stp);
    rxLine <= 1'b1;
  endtask
endmodule

/* File: sim/uart_rx_addr_filter_framing_tb.sv */
// Purpose: Self-checking bench for the filtered serial receiver
// Assumes: Shortened bit time; APB byte address is the index times four
// Notes: Reads queue their expected values; a monitor compares them
`timescale 1ns/1ns
module uart_rx_addr_filter_framing_tb;
  import uaf_pkg::*;
  localparam int BIT = 16; // Shortened bit time
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxLine;
  logic txDoneEvent = 1'b0;
  logic [7:0] rxData;
  logic irq;
  int failures = 0;
  int tests_run = 0;
  logic [64:0] expQ[$]; // Error bit, compare mask, expected data
  logic [64:0] e; // Note being compared
  logic [39:0] r; // Current table row
  logic [7:0] d; // Random payload
  // Control, address, mask, byte, flags {check ninth, ninth, stop, accept}
  logic [39:0] rows[14] = '{40'hf0_00_00_3c_07, 40'hf0_56_fc_55_07, 40'hf0_56_fc_ff_07,
    40'hf0_56_fc_5a_06, 40'hf0_56_fc_55_02, 40'hf0_33_ff_33_07, 40'hf0_33_ff_32_06,
    40'hb0_56_fc_57_07, 40'h70_56_fc_55_03, 40'h70_56_fc_55_00, 40'h70_56_fc_5a_02,
    40'h50_00_00_a5_0b, 40'hd0_56_fc_5a_03, 40'h30_00_00_3c_02};
  // Device under test
  uaf_receiver #(.BIT_DIVIDE(BIT)) dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxLine(rxLine), .txDoneEvent(txDoneEvent),
    .rxData(rxData), .irq(irq));
  // Far-side serial node
  uaf_serial_node #(.BIT(BIT)) node (.clk_sys(clk_sys), .rxLine(rxLine));
  // Free-running system clock
  initial forever #2 clk_sys = ~clk_sys;
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer with a bounded wait for pready
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Register write
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
  endtask
  // Register read with its expectation noted first
  task automatic rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] x,
                    input logic er);
    expQ.push_back({er, m, x});
    xfer(1'b0, idx, 32'h0);
  endtask
  // Monitor: completed reads take the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
      e = expQ.pop_front();
      chk({pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
    end
  end
  // Hang guard
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h3187));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // Reset values and an unmapped place
    rd(IDX_SLAVE_ADDRESS, 32'hff, {24'h0, RST_ADDRESS}, 1'b0);
    rd(IDX_SLAVE_ADDRESS_MASK, 32'hff, {24'h0, RST_MASK}, 1'b0);
    rd(IDX_SERIAL_CONTROL, 32'hff, {24'h0, RST_CONTROL}, 1'b0);
    rd(8'h10, 32'hffffffff, 32'h0, 1'b1);
    // Filter table across modes and addresses
    foreach (rows[i]) begin
      r = rows[i];
      wr(IDX_SERIAL_CONTROL, {24'h0, r[39:32]});
      wr(IDX_SLAVE_ADDRESS, {24'h0, r[31:24]});
      wr(IDX_SLAVE_ADDRESS_MASK, {24'h0, r[23:16]});
      node.send(r[15:8], r[39], r[2], r[1]);
      repeat (4) @(posedge clk_sys);
      rd(IDX_SERIAL_CONTROL, {29'h0, r[3], 2'b01},
         {29'h0, r[1] & r[3], 1'b0, r[0]}, 1'b0);
      if (r[0]) chk({25'h0, rxData}, {25'h0, r[15:8]});
    end
    // Bad stop seen with the check off; status masked keeps irq low
    rd(IDX_IRQ_STATUS, 32'h2, 32'h0, 1'b0);
    chk({32'h0, irq}, 33'h0);
    wr(IDX_IRQ_STATUS, 32'h7);
    // Framing check in mode 3 with random data
    wr(IDX_IRQ_MASK, 32'h3);
    wr(IDX_SERIAL_CONTROL, 32'hd0);
    wr(IDX_POWER_CONTROL, 32'h40);
    d = 8'($urandom);
    node.send(d, 1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge clk_sys);
    chk({25'h0, rxData}, {25'h0, d});
    rd(IDX_SERIAL_CONTROL, 32'h81, 32'h81, 1'b0);
    txDoneEvent <= 1'b1;
    @(posedge clk_sys);
    txDoneEvent <= 1'b0;
    @(posedge clk_sys);
    rd(IDX_IRQ_STATUS, 32'h7, 32'h7, 1'b0);
    chk({32'h0, irq}, 33'h1);
    wr(IDX_IRQ_STATUS, 32'h7);
    repeat (2) @(posedge clk_sys);
    chk({32'h0, irq}, 33'h0);
    // Clear the receive flag but keep the error flag, then a clean frame
    wr(IDX_POWER_CONTROL, 32'h0);
    wr(IDX_SERIAL_CONTROL, 32'hd0);
    wr(IDX_POWER_CONTROL, 32'h40);
    node.send(d, 1'b1, 1'b0, 1'b1);
    repeat (4) @(posedge clk_sys);
    rd(IDX_SERIAL_CONTROL, 32'h81, 32'h81, 1'b0);
    wr(IDX_SERIAL_CONTROL, 32'h50);
    rd(IDX_SERIAL_CONTROL, 32'h80, 32'h0, 1'b0);
    repeat (2) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule
